// *** rtl/serial_comm_unit_consts.vh ***
`ifndef SERIAL_COMM_UNIT_CONSTS_VH
`define SERIAL_COMM_UNIT_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_DATA        12'h000
`define OFS_CONTROL     12'h004
`define OFS_STATUS      12'h008
`define OFS_BAUD        12'h00C
`define OFS_RXDATA      12'h010

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_TXEN        0
`define CTL_TIE         1
`define CTL_TX_END_IRQ_ENABLE        2
`define CTL_SEVEN       3
`define CTL_MPE         4
`define CTL_TWO_STOP    5
`define CTL_MP_BIT_TX_VALUE        6
`define CTL_SMART       7
`define CTL_BLOCK       8
`define CTL_RXEN        9
`define CTL_WIDTH       10
`define CTL_RESET       10'h000

// ****************************************************************
// Status register fields
// ****************************************************************
`define ST_TX_EMPTY_FLAG         0
`define ST_TX_END_FLAG         1
`define ST_PER          2
`define ST_RDRF         3

// ****************************************************************
// Divider reset value is the bit time in clock cycles minus one; error and guard timing in elementary time units
// ****************************************************************
`define BAUD_RESET      16'h0010
`define ERR_SIG_ETU     4'h2
`define ERR_SAMPLE_ETU  4'h1
`define GUARD_ETU       4'h2

`endif

// *** rtl/serial_comm_unit.v ***
// Function
// - Empty flag zero means buffer loaded; move it
// - After move set empty flag and start frame
// - Empty flag with enable raises empty request
// - Low start bit then 8/7 data LSB first
// - Multiprocessor format adds one programmed bit
// - One or two high stop bits
// - Line held high between frames
// - At stop, pending byte loads back-to-back
// - At stop, none pending sets end flag
// - End flag with enable raises end request
// - Smart card idle line left undriven
// - Smart frame start, D0-D7, parity
// - Release line after parity bit
// - Receiver drives error low on parity fault
// - Transmitter resends frame after error signal
// - Block mode receiver never drives error
// - Block mode transmitter ignores error signal
`timescale 1ns/1ns
`default_nettype none
`include "serial_comm_unit_consts.vh"

module serial_comm_unit (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Serial line
  input  wire        line_in,
  output reg         line_out,
  output reg         line_oe,
  // Interrupt requests
  output wire        tx_empty_irq,
  output wire        tx_end_irq
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA  = 3'h2;
  localparam [2:0] ST_EXTRA = 3'h3;
  localparam [2:0] ST_STOP  = 3'h4;
  localparam [2:0] ST_GUARD = 3'h5;

  localparam [1:0] RX_IDLE  = 2'h0;
  localparam [1:0] RX_BITS  = 2'h1;
  localparam [1:0] RX_ERR   = 2'h2;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [`CTL_WIDTH-1:0] serial_control_reg;
  reg  [15:0]           baud_div;
  reg  [7:0]            tx_buffer_reg;
  reg  [7:0]            tx_shift_reg;
  reg                   tx_empty_flag;
  reg                   tx_end_flag;
  reg                   rx_err_flag;
  reg                   rx_full_flag;
  reg  [7:0]            rx_data;
  reg  [2:0]            tx_state;
  reg  [3:0]            bit_cnt;
  reg  [15:0]           tick_cnt;
  reg  [3:0]            etu_cnt;
  reg                   stop_second;
  reg                   err_seen;
  reg                   parity_acc;
  reg  [1:0]            rx_state;
  reg  [3:0]            rx_bits;
  reg  [15:0]           rx_tick;
  reg  [8:0]            rx_sr;
  reg  [3:0]            rx_etu;
  reg                   rx_drive;
  reg                   rx_fault;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~penable & ~pwrite;
  wire smart = serial_control_reg[`CTL_SMART];
  wire block = serial_control_reg[`CTL_BLOCK];
  wire seven = serial_control_reg[`CTL_SEVEN] & ~smart;
  wire etu_end = (tick_cnt == baud_div);
  wire [3:0] data_bits = seven ? 4'h7 : 4'h8;

  // Decoded register hit, used by both read and write paths
  function is_reg;
    input [11:0] a;
    input [11:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  wire hit_any = is_reg(paddr, `OFS_DATA) | is_reg(paddr, `OFS_CONTROL) |
                 is_reg(paddr, `OFS_STATUS) | is_reg(paddr, `OFS_BAUD) |
                 is_reg(paddr, `OFS_RXDATA);
  wire wr_data = wr_en & is_reg(paddr, `OFS_DATA);
  wire wr_stat = wr_en & is_reg(paddr, `OFS_STATUS);
  wire rd_rx   = psel & penable & ~pwrite & is_reg(paddr, `OFS_RXDATA);

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Interrupt requests gated by their enables
  assign tx_empty_irq = tx_empty_flag & serial_control_reg[`CTL_TIE];
  assign tx_end_irq   = tx_end_flag & serial_control_reg[`CTL_TX_END_IRQ_ENABLE];

  // ****************************************************************
  // Bus writes and reads
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg <= `CTL_RESET;
      baud_div           <= `BAUD_RESET;
      tx_buffer_reg      <= 8'h00;
    end else if (wr_en) begin
      if (is_reg(paddr, `OFS_CONTROL))
        serial_control_reg <= pwdata[`CTL_WIDTH-1:0];
      if (is_reg(paddr, `OFS_BAUD))
        baud_div <= pwdata[15:0];
      if (is_reg(paddr, `OFS_DATA))
        tx_buffer_reg <= pwdata[7:0];
    end
  end

  // Read data latched in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= 32'h00000000;
      if (is_reg(paddr, `OFS_DATA))
        prdata <= {24'h000000, tx_buffer_reg};
      if (is_reg(paddr, `OFS_CONTROL))
        prdata <= {22'h000000, serial_control_reg};
      if (is_reg(paddr, `OFS_STATUS))
        prdata <= {28'h0000000, rx_full_flag, rx_err_flag, tx_end_flag, tx_empty_flag};
      if (is_reg(paddr, `OFS_BAUD))
        prdata <= {16'h0000, baud_div};
      if (is_reg(paddr, `OFS_RXDATA))
        prdata <= {24'h000000, rx_data};
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state      <= ST_IDLE;
      tx_shift_reg  <= 8'h00;
      tx_empty_flag <= 1'b1;
      tx_end_flag   <= 1'b1;
      bit_cnt       <= 4'h0;
      tick_cnt      <= 16'h0000;
      etu_cnt       <= 4'h0;
      stop_second   <= 1'b0;
      err_seen      <= 1'b0;
      parity_acc    <= 1'b0;
      line_out      <= 1'b1;
      line_oe       <= 1'b0;
    end else begin
      tick_cnt <= etu_end ? 16'h0000 : tick_cnt + 16'h0001;
      // Software write of the buffer clears the empty flag, and the end flag unless stop start or guard end sets it in that cycle
      if (wr_data) begin
        tx_empty_flag <= 1'b0;
        tx_end_flag   <= 1'b0;
      end
      case (tx_state)
        ST_IDLE: begin
          // Idle: mark level, released in smart mode unless the
          // receiver is signalling a parity error
          line_out <= ~rx_drive;
          line_oe  <= ~smart | rx_drive;
          if (!tx_empty_flag && !wr_data && serial_control_reg[`CTL_TXEN]) begin
            tx_shift_reg  <= tx_buffer_reg;
            tx_empty_flag <= 1'b1;
            tx_state      <= ST_START;
            tick_cnt      <= 16'h0000;
          end
        end
        ST_START: begin
          line_out   <= 1'b0;
          line_oe    <= 1'b1;
          bit_cnt    <= 4'h0;
          parity_acc <= 1'b0;
          if (etu_end)
            tx_state <= ST_DATA;
        end
        ST_DATA: begin
          line_out <= tx_shift_reg[bit_cnt[2:0]];
          if (etu_end) begin
            parity_acc <= parity_acc ^ tx_shift_reg[bit_cnt[2:0]];
            bit_cnt    <= bit_cnt + 4'h1;
            if (bit_cnt == data_bits - 4'h1)
              tx_state <= (smart | serial_control_reg[`CTL_MPE]) ? ST_EXTRA : ST_STOP;
            stop_second <= 1'b0;
          end
        end
        ST_EXTRA: begin
          // Even parity in smart mode, else multiprocessor bit
          line_out <= smart ? parity_acc : serial_control_reg[`CTL_MP_BIT_TX_VALUE];
          if (etu_end) begin
            tx_state <= smart ? ST_GUARD : ST_STOP;
            etu_cnt  <= 4'h0;
            err_seen <= 1'b0;
          end
        end
        ST_GUARD: begin
          line_oe <= 1'b0;
          // Sample the line for the error signal at a fixed point
          if (etu_end && etu_cnt == `ERR_SAMPLE_ETU && !line_in && !block)
            err_seen <= 1'b1;
          if (etu_end) begin
            etu_cnt <= etu_cnt + 4'h1;
            if (etu_cnt == `GUARD_ETU) begin
              if (err_seen) begin
                tx_state <= ST_START;
              end else if (!tx_empty_flag && !wr_data) begin
                tx_shift_reg  <= tx_buffer_reg;
                tx_empty_flag <= 1'b1;
                tx_state      <= ST_START;
              end else begin
                tx_end_flag <= 1'b1;
                tx_state    <= ST_IDLE;
              end
            end
          end
        end
        ST_STOP: begin
          line_out <= 1'b1;
          if (tick_cnt == 16'h0000 && !stop_second) begin
            // Check for the next byte as the stop bit begins
            if (!tx_empty_flag && !wr_data) begin
              tx_shift_reg  <= tx_buffer_reg;
              tx_empty_flag <= 1'b1;
              err_seen      <= 1'b1;
            end else begin
              tx_end_flag <= 1'b1;
              err_seen    <= 1'b0;
            end
          end
          if (etu_end) begin
            if (serial_control_reg[`CTL_TWO_STOP] && !stop_second)
              stop_second <= 1'b1;
            else
              tx_state <= err_seen ? ST_START : ST_IDLE;
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Smart card receiver and error signalling
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state     <= RX_IDLE;
      rx_bits      <= 4'h0;
      rx_tick      <= 16'h0000;
      rx_sr        <= 9'h000;
      rx_etu       <= 4'h0;
      rx_drive     <= 1'b0;
      rx_fault     <= 1'b0;
      rx_err_flag  <= 1'b0;
      rx_full_flag <= 1'b0;
      rx_data      <= 8'h00;
    end else begin
      // Software clears: error by writing zero, full by reading data
      if (wr_stat && !pwdata[`ST_PER])
        rx_err_flag <= 1'b0;
      if (rd_rx)
        rx_full_flag <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_drive <= 1'b0;
          // Blocked while a block-mode error is outstanding
          if (smart && serial_control_reg[`CTL_RXEN] && tx_state == ST_IDLE &&
              !line_in && !(block && rx_err_flag)) begin
            rx_state <= RX_BITS;
            rx_bits  <= 4'h0;
            rx_tick  <= 16'h0000;
          end
        end
        RX_BITS: begin
          rx_tick <= (rx_tick == baud_div) ? 16'h0000 : rx_tick + 16'h0001;
          if (rx_tick == {1'b0, baud_div[15:1]}) begin
            rx_sr   <= {line_in, rx_sr[8:1]};
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == 4'h9) begin
              // Parity sampled mid-bit; the tail state waits out the
              // rest of the bit so a low parity bit is no new start
              rx_etu   <= 4'h0;
              rx_state <= RX_ERR;
              rx_fault <= ^rx_sr[8:0] ^ line_in;
              // Good frames hand the byte over, bad ones raise the flag
              if (^rx_sr[8:0] ^ line_in) begin
                rx_err_flag <= 1'b1;
              end else begin
                rx_data      <= rx_sr[8:1];
                rx_full_flag <= 1'b1;
              end
            end
          end
        end
        RX_ERR: begin
          rx_tick <= (rx_tick == baud_div) ? 16'h0000 : rx_tick + 16'h0001;
          // Counted in bit times from the end of the parity bit
          if (rx_tick == baud_div) begin
            rx_etu <= rx_etu + 4'h1;
            // Error signal only in normal mode, never in block mode
            if (rx_etu == 4'h0)
              rx_drive <= rx_fault & ~block;
            // Release after the error length, then one quiet bit time
            if (rx_etu == `ERR_SIG_ETU)
              rx_drive <= 1'b0;
            if (rx_etu == `ERR_SIG_ETU + 4'h1)
              rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** test/serial_comm_unit_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "serial_comm_unit_consts.vh"
module serial_comm_unit_sva (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line and requests
  input wire logic        line_out,
  input wire logic        line_oe,
  input wire logic        tx_empty_irq,
  input wire logic        tx_end_irq
);
  logic [9:0]  ctl;
  logic [15:0] baud;
  wire logic   wr   = psel && penable && pwrite && pready;
  wire logic   fast = baud == 16'h0003;
  wire logic   sc   = ctl[`CTL_SMART];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Shadow of control and divider writes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl  <= `CTL_RESET;
      baud <= `BAUD_RESET;
    end else if (wr && paddr == `OFS_CONTROL) begin
      ctl  <= pwdata[9:0];
    end else if (wr && paddr == `OFS_BAUD) begin
      baud <= pwdata[15:0];
    end
  end
  // Buffer write with the empty request enabled (bit 1)
  sequence s_buf_wr;
    wr && paddr == `OFS_DATA && ctl[1] && fast;
  endsequence
  sequence s_refill;
    ##1 !tx_empty_irq ##[1:200] tx_empty_irq;
  endsequence
  property p_refill;    s_buf_wr |-> s_refill; endproperty
  property p_empty_msk; tx_empty_irq |-> ctl[1]; endproperty
  property p_end_msk;   tx_end_irq |-> ctl[2]; endproperty
  property p_end_clr;   wr && paddr == `OFS_DATA |=> !tx_end_irq; endproperty
  property p_end_mark;  tx_end_irq && !sc |-> line_out; endproperty
  property p_start;     !sc && fast && line_oe && $fell(line_out) |-> !line_out[*4]; endproperty
  property p_async_oe;  presetn && !sc ##1 !sc |-> line_oe; endproperty
  property p_guard;     sc && fast && $fell(line_oe) |-> !line_oe[*4]; endproperty
  property p_frame;     sc && fast && $rose(line_oe) |-> line_oe[*8]; endproperty
  property p_slverr;    pslverr |-> psel && penable; endproperty
  a_refill: assert property (p_refill)
    else $error("empty flag did not return");
  a_empty_msk: assert property (p_empty_msk)
    else $error("empty request while disabled");
  a_end_msk: assert property (p_end_msk)
    else $error("end request while disabled");
  a_end_clr: assert property (p_end_clr)
    else $error("end request kept after buffer write");
  a_end_mark: assert property (p_end_mark)
    else $error("line low after end of transmission");
  a_start: assert property (p_start)
    else $error("low bit shorter than one bit time");
  a_async_oe: assert property (p_async_oe)
    else $error("line released in async mode");
  a_guard: assert property (p_guard)
    else $error("line driven again too soon after frame");
  a_frame: assert property (p_frame)
    else $error("smart frame drive too short");
  a_slverr: assert property (p_slverr)
    else $error("error response outside access phase");
endmodule
bind serial_comm_unit serial_comm_unit_sva u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .line_out, .line_oe, .tx_empty_irq, .tx_end_irq
);
`default_nettype wire

// *** test/serial_station.sv ***
`timescale 1ns/1ns
`default_nettype none
module serial_station #(
  parameter int BIT = 4
) (
  // Clock and unit drive
  input  wire logic       clk,
  input  wire logic       line_out,
  input  wire logic       line_oe,
  // Frame set-up
  input  wire logic [3:0] nbits,
  input  wire logic       smart,
  input  wire logic       block,
  // Resolved line
  output wire logic       line_in
);
  logic drv_low = 1'b0;
  logic err_req = 1'b0;
  int   rx_q[$];
  // Pull-up holds a released line high
  assign line_in = (line_oe ? line_out : 1'b1) & !drv_low;
  // ****************************************
  // Receiver, sampling each bit mid-way
  // ****************************************
  always begin
    int v;
    @(negedge line_in);
    v = 0;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT) @(posedge clk);
      v = v | (int'(line_in) << i);
    end
    if (smart) begin
      repeat (BIT / 2) @(posedge clk);
      // Error pulse only when commanded, never in block mode
      if (err_req && !block) begin
        err_req = 1'b0;
        drv_low <= 1'b1;
        repeat (2 * BIT) @(posedge clk);
        drv_low <= 1'b0;
      end
    end
    rx_q.push_back(v);
  end
  // Sends one smart frame on the shared line: start, D0-D7, parity
  task automatic send(input logic [8:0] f);
    drv_low <= 1'b1;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      drv_low <= !f[i];
      repeat (BIT) @(posedge clk);
    end
    drv_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/serial_comm_unit_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "serial_comm_unit_consts.vh"
module serial_comm_unit_bench;
  logic        pclk, presetn, psel, penable, pwrite, sm, bl;
  logic [11:0] paddr;
  logic [31:0] pwdata, r;
  logic [3:0]  nb;
  logic        e;
  logic [7:0]  x;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, line_in, line_out, line_oe, tx_empty_irq, tx_end_irq;
  logic [31:0] seed = 32'h75DD;
  logic [9:0]  cfg [8] = '{10'h007, 10'h00F, 10'h027, 10'h017,
                           10'h057, 10'h01D, 10'h087, 10'h187};
  int          checked = 0;
  int          miscompares = 0;
  int          exp_q[$];
  serial_comm_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_in, .line_out, .line_oe, .tx_empty_irq, .tx_end_irq);
  serial_station #(.BIT(4)) st (.clk(pclk), .line_out, .line_oe, .nbits(nb),
    .smart(sm), .block(bl), .line_in);
  // ****************************************
  // Clock, random source, bus and compare tasks
  // ****************************************
  always #2 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected frame content as the station collects it
  function automatic int expv(logic [9:0] c, logic [7:0] b);
    int v;
    v = c[`CTL_SEVEN] ? b[6:0] : b;
    if (c[`CTL_SMART]) v = v | (int'(^b) << 8);
    else if (c[`CTL_MPE]) v = v | (int'(c[6]) << (c[`CTL_SEVEN] ? 7 : 8));
    return v;
  endfunction
  // Send cnt bytes in one format, optionally with a commanded error pulse
  task automatic run(input logic [9:0] c, input int cnt);
    int b;
    nb <= 4'((c[`CTL_SEVEN] ? 7 : 8) + (c[`CTL_MPE] | c[`CTL_SMART]));
    sm <= c[`CTL_SMART];
    bl <= c[`CTL_BLOCK];
    apb(1'b1, `OFS_CONTROL, 32'(c));
    st.err_req = c[`CTL_SMART];
    for (int i = 0; i < cnt; i++) begin
      b = int'(rnd() & 32'h0000_00FF);
      apb(1'b1, `OFS_DATA, 32'(b));
      exp_q.push_back(expv(c, b[7:0]));
      if (c[`CTL_SMART] && !c[`CTL_BLOCK]) exp_q.push_back(expv(c, b[7:0]));
    end
    // Let the last buffer write clear the end flag before waiting on it
    @(posedge pclk);
    while (tx_end_irq !== 1'b1) begin
      @(posedge pclk);
    end
    repeat (200) @(posedge pclk);
    chk(32'(st.rx_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && st.rx_q.size() > 0) begin
      chk(32'(st.rx_q.pop_front()), 32'(exp_q.pop_front()));
    end
    chk({30'h0, tx_empty_irq, tx_end_irq}, {30'h0, c[1], 1'b1});
    exp_q.delete();
    st.rx_q.delete();
  endtask
  // Station sends one smart frame; count cycles of error drive by the unit
  task automatic rx_frame(input logic [7:0] d, input logic bad, input int drv);
    int low;
    low = 0;
    st.send({^d ^ bad, d});
    repeat (24) begin
      @(posedge pclk);
      if (line_oe === 1'b1 && line_out === 1'b0) low++;
    end
    chk(32'(low), 32'(drv));
  endtask
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; nb = 4'h8; sm = 1'b0; bl = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(r, 32'h0000_0003);
    apb(1'b0, `OFS_CONTROL, 32'h0);
    chk(r, 32'h0000_0000);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({r[30:0], e}, 32'h0000_0001);
    apb(1'b1, `OFS_BAUD, 32'h0000_0003);
    for (int k = 0; k < 8; k++) begin
      run(cfg[k], (k == 0) ? 2 : 1);
    end
    // Smart card reception: normal mode, then block mode
    st.err_req = 1'b0;
    apb(1'b1, `OFS_CONTROL, 32'h0000_0280);
    x = 8'(rnd());
    rx_frame(x, 1'b0, 0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(r, 32'h0000_000B);
    apb(1'b0, `OFS_RXDATA, 32'h0);
    chk(r, {24'h0, x});
    rx_frame(8'(rnd()), 1'b1, 4 * `ERR_SIG_ETU);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(r, 32'h0000_0007);
    apb(1'b1, `OFS_STATUS, 32'h0);
    apb(1'b1, `OFS_CONTROL, 32'h0000_0380);
    rx_frame(8'(rnd()), 1'b1, 0);
    rx_frame(8'(rnd()), 1'b0, 0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(r, 32'h0000_0007);
    apb(1'b1, `OFS_STATUS, 32'h0);
    x = 8'(rnd());
    rx_frame(x, 1'b0, 0);
    apb(1'b0, `OFS_RXDATA, 32'h0);
    chk(r, {24'h0, x});
    stop_test;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
